// ==== dspt_pkg.sv ====
`default_nettype none
// ======================================================================
// shared constants and types of the dual-slope pwm timer
package dspt_pkg;

  // ====================================================================
  // register map
  localparam logic [5:0] DSPT_CTRL_A_IO_OFS = 6'h2f;
  localparam logic [7:0] DSPT_DATA_SPACE_BIAS = 8'h20;
  localparam logic [7:0] DSPT_CTRL_A_RESET = 8'h00;
  localparam int DSPT_ACT_A_LSB = 6;
  localparam int DSPT_ACT_B_LSB = 4;
  localparam int DSPT_ACT_C_LSB = 2;
  localparam int DSPT_WGM_LO_LSB = 0;

  // ====================================================================
  // counter and modes
  localparam int DSPT_CNT_W = 16;
  localparam logic [15:0] DSPT_BOTTOM = 16'h0000;
  localparam logic [15:0] DSPT_MIN_TOP = 16'h0003;
  localparam logic [3:0] DSPT_WGM_PFC_CAPTURE = 4'h8;
  localparam logic [3:0] DSPT_WGM_PFC_CMP_A = 4'h9;
  localparam int DSPT_CHANNELS = 3;

  // ====================================================================
  // prescaler divisors
  localparam logic [10:0] DSPT_DIV_1 = 11'h001;
  localparam logic [10:0] DSPT_DIV_8 = 11'h008;
  localparam logic [10:0] DSPT_DIV_64 = 11'h040;
  localparam logic [10:0] DSPT_DIV_256 = 11'h100;
  localparam logic [10:0] DSPT_DIV_1024 = 11'h400;

  typedef enum logic [2:0] {
    DSPT_CS_STOP = 3'b000,
    DSPT_CS_DIV1 = 3'b001,
    DSPT_CS_DIV8 = 3'b010,
    DSPT_CS_DIV64 = 3'b011,
    DSPT_CS_DIV256 = 3'b100,
    DSPT_CS_DIV1024 = 3'b101
  } dspt_clk_sel_t;

  typedef enum logic [1:0] {
    DSPT_ACT_OFF = 2'b00,
    DSPT_ACT_TOGGLE = 2'b01,
    DSPT_ACT_NONINV = 2'b10,
    DSPT_ACT_INV = 2'b11
  } dspt_action_t;

  typedef enum logic {
    DSPT_DIR_UP = 1'b0,
    DSPT_DIR_DOWN = 1'b1
  } dspt_dir_t;

  // ====================================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dspt_reg_req_t;

  typedef struct packed {
    logic wrap_flag;
    logic capture_flag;
    logic [2:0] match_flag;
  } dspt_flags_t;

  typedef struct packed {
    logic [15:0] count;
    dspt_dir_t dir;
    logic [2:0][15:0] cmp_act;
    logic [7:0] ctrl_a;
    logic [2:0] out;
    dspt_flags_t flags;
    logic [7:0] rdata;
  } dspt_state_t;

  typedef struct packed {
    logic [10:0] div_cnt;
    logic tick;
  } dspt_presc_state_t;

endpackage
`default_nettype wire

// ==== dspt_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// prescaler: turns the io clock into a one-cycle timer tick enable
module dspt_prescaler
#(
  parameter int DIV_W = 11
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // divisor choice
  input wire dspt_pkg::dspt_clk_sel_t clock_select,
  // tick out
  output logic timer_tick_enable
);
  import dspt_pkg::*;

  // ====================================================================
  // elaboration check: counter must reach the largest divisor
  if (DIV_W < 11)
  begin : g_bad_width
    $error("dspt_prescaler: DIV_W must be at least 11");
  end

  dspt_presc_state_t state_reg;
  dspt_presc_state_t state_next;

  // divisor lookup, zero means stopped
  function automatic logic [10:0] divisor(input dspt_clk_sel_t sel);
    case (sel)
      DSPT_CS_DIV1: divisor = DSPT_DIV_1;
      DSPT_CS_DIV8: divisor = DSPT_DIV_8;
      DSPT_CS_DIV64: divisor = DSPT_DIV_64;
      DSPT_CS_DIV256: divisor = DSPT_DIV_256;
      DSPT_CS_DIV1024: divisor = DSPT_DIV_1024;
      default: divisor = 11'h000;
    endcase
  endfunction

  // ====================================================================
  // free-running divider; a stopped prescaler holds at zero
  always_comb
  begin
    logic [10:0] div;
    div = divisor(clock_select);
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (div == 11'h000)
    begin
      state_next.div_cnt = 11'h000;
    end
    else if (state_reg.div_cnt >= div - 11'h001)
    begin
      state_next.div_cnt = 11'h000; // also recovers after a divisor shrink
      state_next.tick = 1'b1; // RULE_15
    end
    else
    begin
      state_next.div_cnt = state_reg.div_cnt + 11'h001;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  // registered so the tick is glitch free, one cycle behind the divider
  assign timer_tick_enable = state_reg.tick;

endmodule // dspt_prescaler
`default_nettype wire

// ==== dspt_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// symmetric dual-slope pwm timer, three compare channels
// Operation
// RULE_01 - waveform select 8 or 9 enables mode
// RULE_02 - count up from zero, then back down
// RULE_03 - top from capture (8) or compare A (9)
// RULE_04 - count holds top for exactly one tick
// RULE_05 - noninverting: clear upward match, set downward
// RULE_06 - action 2 noninverted, action 3 inverted
// RULE_07 - reload compares and set wrap at zero
// RULE_08 - top reached sets match A or capture flag
// RULE_09 - channel match flag on count equals compare
// RULE_10 - software keeps top at least every compare
// RULE_11 - top from three up to sixteen bits
// RULE_12 - pin driven only when direction bit outputs
// RULE_13 - compare zero low, compare top high
// RULE_14 - mode 9, action A 1 toggles
// RULE_15 - tick divides io clock by prescaler factor
// RULE_16 - synchronous design, tick is clock enable
// RULE_17 - control A layout: actions and low select
// RULE_18 - control A at io 0x2f, data 0x4f
// RULE_19 - upper select bits from control register B
// RULE_20 - nonzero action overrides pin port function
// RULE_21 - turn upward at zero, move only on ticks
module dspt_timer
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire dspt_pkg::dspt_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // loose control inputs
  input wire logic [1:0] waveform_control_b_hi,
  input wire dspt_pkg::dspt_clk_sel_t clock_select,
  input wire logic [15:0] capture_top_register,
  input wire logic [15:0] compare_value_a,
  input wire logic [15:0] compare_value_b,
  input wire logic [15:0] compare_value_c,
  input wire logic [2:0] pin_direction_bit,
  input wire dspt_pkg::dspt_flags_t flag_clear,
  // status outputs
  output logic [15:0] count_value,
  output dspt_pkg::dspt_flags_t flags,
  // compare output pins
  output logic [2:0] compare_output_pin,
  output logic [2:0] compare_output_oe_n
);
  import dspt_pkg::*;

  // ====================================================================
  // state and helpers
  dspt_state_t state_reg;
  dspt_state_t state_next;
  logic timer_tick_enable;
  logic [3:0] waveform_select;
  logic dual_slope;
  logic [15:0] top_value;
  logic [2:0][15:0] cmp_buf;
  logic ctrl_a_hit;

  // one channel's action field out of control A
  function automatic dspt_action_t action_of(input logic [7:0] ctrl, input int ch);
    logic [1:0] f;
    f = 2'b00;
    case (ch)
      0: f = ctrl[DSPT_ACT_A_LSB +: 2]; // RULE_17
      1: f = ctrl[DSPT_ACT_B_LSB +: 2];
      2: f = ctrl[DSPT_ACT_C_LSB +: 2];
      default: f = 2'b00;
    endcase
    action_of = dspt_action_t'(f);
  endfunction

  // ====================================================================
  // tick source, an enable on core_clk and not a clock of its own
  dspt_prescaler #(
    .DIV_W(11)
  ) u_prescaler (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .clock_select(clock_select),
    .timer_tick_enable(timer_tick_enable) // RULE_16
  );

  // ====================================================================
  // mode decode and top selection
  assign waveform_select = {waveform_control_b_hi, state_reg.ctrl_a[DSPT_WGM_LO_LSB +: 2]}; // RULE_19
  assign dual_slope = (waveform_select == DSPT_WGM_PFC_CAPTURE)
    || (waveform_select == DSPT_WGM_PFC_CMP_A); // RULE_01
  // mode 9 uses the active (buffered) compare A so top only moves at bottom
  assign top_value = (waveform_select == DSPT_WGM_PFC_CAPTURE)
    ? capture_top_register : state_reg.cmp_act[0]; // RULE_03 RULE_11
  assign cmp_buf = {compare_value_c, compare_value_b, compare_value_a};

  // both the io offset and the data-space alias decode here
  assign ctrl_a_hit = reg_req.io_space
    ? (reg_req.addr == {2'b00, DSPT_CTRL_A_IO_OFS})
    : (reg_req.addr == ({2'b00, DSPT_CTRL_A_IO_OFS} + DSPT_DATA_SPACE_BIAS)); // RULE_18

  // ====================================================================
  // next-state logic
  always_comb
  begin
    logic at_top;
    logic at_bottom;
    logic up_phase;
    logic match;
    dspt_action_t act;
    at_top = 1'b0;
    at_bottom = 1'b0;
    up_phase = 1'b0;
    match = 1'b0;
    act = DSPT_ACT_OFF;
    state_next = state_reg;

    // register port: write control A, read answers one cycle later
    if (reg_req.wr && ctrl_a_hit)
    begin
      state_next.ctrl_a = reg_req.wdata; // RULE_17
    end
    if (reg_req.rd)
    begin
      state_next.rdata = ctrl_a_hit ? state_reg.ctrl_a : 8'h00;
    end

    // software clears first, so a same-tick hardware set overrides it
    state_next.flags = state_reg.flags & ~flag_clear;

    if (dual_slope && timer_tick_enable) // RULE_21
    begin
      at_top = (state_reg.count >= top_value);
      at_bottom = (state_reg.count == DSPT_BOTTOM);
      // zero counts as rising and top as falling: this gives the
      // solid low at compare zero and solid high at compare top
      up_phase = at_bottom || (state_reg.dir == DSPT_DIR_UP && !at_top); // RULE_13

      // compare outputs act on the values active during this tick
      for (int ch = 0; ch < DSPT_CHANNELS; ch++)
      begin
        match = (state_reg.count == state_reg.cmp_act[ch]);
        act = action_of(state_reg.ctrl_a, ch);
        if (match)
        begin
          state_next.flags.match_flag[ch] = 1'b1; // RULE_09
          case (act)
            DSPT_ACT_NONINV: state_next.out[ch] = !up_phase; // RULE_05 RULE_06
            DSPT_ACT_INV: state_next.out[ch] = up_phase; // RULE_05 RULE_06
            DSPT_ACT_TOGGLE:
            begin
              // toggle exists only for channel A with top from compare A
              if (ch == 0 && waveform_select == DSPT_WGM_PFC_CMP_A)
              begin
                state_next.out[ch] = !state_reg.out[ch]; // RULE_14
              end
            end
            default: state_next.out[ch] = state_reg.out[ch];
          endcase
        end
      end

      // counting: bottom wins over top, so a top still at zero before the
      // first reload cannot wrap the count round to all ones
      if (at_bottom)
      begin
        state_next.dir = DSPT_DIR_UP; // RULE_21
        state_next.count = state_reg.count + 16'h0001; // RULE_02
      end
      else if (at_top)
      begin
        // stay on top for one tick, then fall
        state_next.dir = DSPT_DIR_DOWN;
        state_next.count = state_reg.count - 16'h0001; // RULE_02 RULE_04
        if (waveform_select == DSPT_WGM_PFC_CAPTURE)
        begin
          state_next.flags.capture_flag = 1'b1; // RULE_08
        end
        else
        begin
          state_next.flags.match_flag[0] = 1'b1; // RULE_08
        end
      end
      else if (state_reg.dir == DSPT_DIR_UP)
      begin
        state_next.count = state_reg.count + 16'h0001;
      end
      else
      begin
        state_next.count = state_reg.count - 16'h0001;
      end

      // double buffer reload at bottom keeps both slopes equal
      if (at_bottom)
      begin
        state_next.cmp_act = cmp_buf; // RULE_07
        state_next.flags.wrap_flag = 1'b1; // RULE_07
      end
    end
  end

  // ====================================================================
  // state register, frozen while clk_en is low
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.ctrl_a <= DSPT_CTRL_A_RESET;
      state_reg.dir <= DSPT_DIR_UP;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  // ====================================================================
  // outputs
  assign reg_rdata = state_reg.rdata;
  assign count_value = state_reg.count;
  assign flags = state_reg.flags;

  // pin driven when the channel's action is nonzero and its direction
  // bit says output; otherwise the pin is left to the port logic
  always_comb
  begin
    for (int ch = 0; ch < DSPT_CHANNELS; ch++)
    begin
      compare_output_pin[ch] = state_reg.out[ch];
      compare_output_oe_n[ch] = !((action_of(state_reg.ctrl_a, ch) != DSPT_ACT_OFF)
        && pin_direction_bit[ch]); // RULE_12 RULE_20
    end
  end

  // top below a compare value just never matches that channel; software
  // must keep top at or above every compare value
  // RULE_10

endmodule // dspt_timer
`default_nettype wire

// ==== dspt_load.sv ====
`timescale 1ns/1ps
`default_nettype none
// ======================================
// load on the compare pins
module dspt_load
(
  // pins
  input wire logic core_clk,
  input wire logic [2:0] pin,
  input wire logic [2:0] oe_n,
  // seen level
  output logic [2:0] pad
);
  logic [2:0] held = 3'b000;
  // last level seen, so a released pin cannot fake a match
  always @(posedge core_clk) held <= pad;
  // undriven pin flips each cycle
  always_comb
  begin
    for (int i = 0; i < 3; i++) pad[i] = oe_n[i] ? ~held[i] : pin[i];
  end
endmodule // dspt_load
`default_nettype wire

// ==== dspt_timer_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ======================================
// port checker
module dspt_chk
(
  // clock and inputs
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire dspt_pkg::dspt_reg_req_t reg_req,
  input wire logic [2:0] pin_direction_bit,
  input wire dspt_pkg::dspt_clk_sel_t clock_select,
  // outputs
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] count_value,
  input wire dspt_pkg::dspt_flags_t flags,
  input wire logic [2:0] compare_output_oe_n
);
  import dspt_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic hit;
  // control a decode, both address spaces
  assign hit = reg_req.io_space ? reg_req.addr == 8'h2f : reg_req.addr == 8'h4f;
  sequence s_quiet7;
    $stable(count_value) [*7];
  endsequence
  chk_count_step: assert property (
    $changed(count_value) |-> count_value - $past(count_value) inside {16'h0001, 16'hffff})
    else $error("count jumped");
  chk_bottom_turn: assert property (
    $past(count_value) == 16'h0000 && count_value != 16'h0000 |-> count_value == 16'h0001)
    else $error("no turn at bottom");
  chk_wrap_bottom: assert property (
    $rose(flags.wrap_flag) |-> count_value <= 16'h0001)
    else $error("wrap away from bottom");
  chk_rdata_hold: assert property (
    !(reg_req.rd && clk_en) |=> $stable(reg_rdata))
    else $error("read data moved");
  chk_miss_zero: assert property (
    reg_req.rd && clk_en && !hit |=> reg_rdata == 8'h00)
    else $error("miss read not zero");
  chk_oe_dir: assert property (
    (~pin_direction_bit & ~compare_output_oe_n) == 3'b000)
    else $error("pin driven as input");
  chk_oe_action: assert property (
    reg_req.wr && clk_en && hit && reg_req.wdata[7:6] != 2'b00 && pin_direction_bit[0]
    |=> !compare_output_oe_n[0])
    else $error("pin a not enabled");
  chk_count_freeze: assert property (
    !clk_en |=> $stable(count_value))
    else $error("count moved while disabled");
  chk_tick_div: assert property (
    $changed(count_value) && clock_select == DSPT_CS_DIV8 && $stable(clock_select)
    |=> s_quiet7)
    else $error("tick faster than divide by 8");
endmodule // dspt_chk
bind dspt_timer dspt_chk chk_u (.core_clk, .rst_n, .clk_en, .reg_req, .pin_direction_bit,
  .clock_select, .reg_rdata, .count_value, .flags, .compare_output_oe_n);
`default_nettype wire

// ==== dspt_timer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ======================================
// timer testbench
module dspt_timer_tb;
  import dspt_pkg::*;
  logic core_clk, rst_n, clk_en, up, last_a;
  dspt_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic [1:0] waveform_control_b_hi;
  dspt_clk_sel_t clock_select;
  logic [15:0] capture_top_register, compare_value_a, compare_value_b, compare_value_c;
  logic [15:0] count_value, prev;
  logic [2:0] pin_direction_bit, compare_output_pin, compare_output_oe_n, pad;
  dspt_flags_t flag_clear, flags;
  int err_count, checked, n;
  logic [10:0] div_tab[5] = '{11'h001, 11'h008, 11'h040, 11'h100, 11'h400};
  dspt_timer dut_u (.core_clk, .rst_n, .clk_en, .reg_req, .reg_rdata, .waveform_control_b_hi,
    .clock_select, .capture_top_register, .compare_value_a, .compare_value_b, .compare_value_c,
    .pin_direction_bit, .flag_clear, .count_value, .flags, .compare_output_pin,
    .compare_output_oe_n);
  dspt_load load_u (.core_clk, .pin(compare_output_pin), .oe_n(compare_output_oe_n), .pad);
  // 20 mhz clock
  initial
  begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask
  // one strobe, then an idle cycle so strobes never merge
  task automatic access(input logic wr, input logic io, input logic [7:0] a, input logic [7:0] d);
    reg_req <= '{wr, ~wr, io, a, d};
    @(negedge core_clk);
    reg_req <= '0;
    @(negedge core_clk);
  endtask
  task automatic rd_chk(input logic io, input logic [7:0] a, input logic [7:0] e);
    access(1'b0, io, a, 8'h00);
    check("control a", {8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic wait_cnt(input logic [15:0] v);
    n = 0;
    while (count_value !== v && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
    check("count reached", count_value, v);
  endtask
  task automatic next_change();
    prev = count_value;
    n = 0;
    while (count_value === prev && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic frozen();
    repeat (2) @(negedge core_clk);
    prev = count_value;
    repeat (10) @(negedge core_clk);
    check("frozen count", count_value, prev);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog, a few times the expected run
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    rst_n = 0;
    clk_en = 1;
    reg_req = '0;
    waveform_control_b_hi = 2'b00;
    clock_select = DSPT_CS_DIV1;
    capture_top_register = 16'h0005;
    compare_value_a = 16'h0003;
    compare_value_b = 16'h0001;
    compare_value_c = 16'h0000;
    pin_direction_bit = 3'b111;
    flag_clear = '0;
    repeat (12) @(negedge core_clk);
    rst_n = 1;
    check("oe reset", compare_output_oe_n, 3'b111);
    rd_chk(1'b1, 8'h2f, 8'h00);
    access(1'b1, 1'b0, 8'h4f, 8'h6d);
    rd_chk(1'b1, 8'h2f, 8'h6d);
    rd_chk(1'b0, 8'h2f, 8'h00);
    access(1'b1, 1'b1, 8'h4f, 8'hff);
    rd_chk(1'b1, 8'h2f, 8'h6d);
    clk_en = 0;
    access(1'b1, 1'b1, 8'h2f, 8'h00);
    clk_en = 1;
    rd_chk(1'b1, 8'h2f, 8'h6d);
    check("oe on", compare_output_oe_n, 3'b000);
    frozen();
    waveform_control_b_hi = 2'b10;
    wait_cnt(16'h0003);
    last_a = pad[0];
    // mode 9, top 3: a toggles, b non-inverted at 1, c inverted at 0
    for (int i = 0; i < 24; i++)
    begin
      prev = count_value;
      @(negedge core_clk);
      flag_clear <= '0;
      if (prev == 16'h0003) up = 0;
      if (prev == 16'h0000) up = 1;
      check("count", count_value, up ? prev + 16'h0001 : prev - 16'h0001);
      // pins move on the tick that leaves the matching count
      if (prev == 16'h0001) check("pin b", pad[1], !up);
      check("pin c", pad[2], 1'b1);
      if (prev == 16'h0003)
      begin
        check("pin a", pad[0], !last_a);
        last_a = pad[0];
      end
      // wrap and match c are set in the very tick of the clear
      if (count_value == 16'h0002 && up) check("flags", flags, 5'h16);
      if (count_value == 16'h0000)
      begin
        check("flags", flags, 5'h17);
        flag_clear <= 5'h1f;
      end
    end
    // every divisor: spacing of the second full tick interval
    for (int i = 0; i < 5; i++)
    begin
      clock_select = dspt_clk_sel_t'(3'(i + 1));
      repeat (3) next_change();
      check("tick spacing", 16'(n), {5'h00, div_tab[i]});
    end
    clock_select = DSPT_CS_STOP;
    frozen();
    access(1'b1, 1'b1, 8'h2f, 8'ha0);
    compare_value_a = 16'h0005;
    compare_value_b = 16'h0000;
    clock_select = DSPT_CS_DIV1;
    wait_cnt(16'h0005);
    // the flag shows after the tick spent on top
    @(negedge core_clk);
    check("capture flag", flags.capture_flag, 1'b1);
    wait_cnt(16'h0000);
    wait_cnt(16'h0005);
    repeat (12)
    begin
      @(negedge core_clk);
      check("pin a high", pad[0], 1'b1);
    end
    check("pin b low", pad[1], 1'b0);
    check("oe c off", compare_output_oe_n, 3'b100);
    pin_direction_bit = 3'b110;
    @(negedge core_clk);
    check("oe a input", compare_output_oe_n, 3'b101);
    waveform_control_b_hi = 2'b00;
    frozen();
    report_and_stop();
  end
endmodule // dspt_timer_tb
`default_nettype wire
